// >>> logic/smc_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - The master prescaled clock period is 32 ns times the 16-bit prescaler field.
// - A prescaler value of zero or one stops the master prescaled clock.
// - A slow boot configuration loads the prescaler with 0x0139 at start-up.
// - A fast boot configuration loads the prescaler with 0x0053 at start-up.
// - The master clock stays low for half the programmed period on average, rounded down or up to a whole clock.
// - With ignore-arbitration set the master carries on whether it won or lost.
// - With ignore-checksum set every initialisation checksum passes.
// - The slave glitch mode sets the slave line filter delay: 1 us, 100 ns or none.
// - The master glitch mode sets the master line filter delay: 1 us, 100 ns or none.
// - With time-out disable set neither port reports a bus time-out.
// - The master re-arbitrates after a loss and aborts with a flag after 16 in a row.
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        boot_fast_mode,
  output logic             boot_initialised,
  input  wire logic        master_port_clock_line_i,
  output logic             master_port_clock_line_o,
  output logic             master_port_clock_line_oe,
  input  wire logic        master_port_data_line_i,
  output logic             master_port_data_line_o,
  output logic             master_port_data_line_oe,
  input  wire logic        slave_port_clock_line_i,
  output logic             slave_port_clock_line_o,
  output logic             slave_port_clock_line_oe,
  input  wire logic        slave_port_data_line_i,
  output logic             slave_port_data_line_o,
  output logic             slave_port_data_line_oe,
  input  wire logic        mst_run,
  input  wire logic        mst_data_out,
  input  wire logic        mst_txn_done,
  output logic             mst_clk_in,
  output logic             mst_data_in,
  output logic             mst_half_tick,
  output logic             arb_abort,
  input  wire logic        slv_data_low,
  output logic             slv_clk_in,
  output logic             slv_data_in,
  output logic             master_timeout,
  output logic             slave_timeout,
  input  wire logic        csum_check,
  input  wire logic        csum_ok,
  output logic             csum_error
);

  // ******
  // Reset release
  // ******
  logic rst_meta_ff;
  logic rst_sync_ff;

  // Asynchronous assert, two-stage release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ******
  // Declarations
  // ******
  logic             [15:0] prescale_ff;
  logic                    ign_arb_ff;
  logic                    ign_csum_ff;
  smc_glitch_mode_t        slv_mode_ff;
  smc_glitch_mode_t        mst_mode_ff;
  logic                    to_dis_ff;
  logic                    boot_done_ff;
  logic                    lost_arbitration_flag_ff;
  logic                    mst_to_flag_ff;
  logic                    slv_to_flag_ff;
  logic                    csum_flag_ff;
  logic             [4:0]  loss_cnt_ff;
  smc_arb_state_t          arb_ff;
  smc_arb_state_t          nxt_arb;
  logic                    scl_high_ff;
  logic                    sda_drive_ff;
  logic                    loss_evt;
  logic                    abort_evt;
  logic                    bus_idle;
  logic                    wr_ctrl;
  logic                    wr_stat;
  logic             [31:0] ctrl_rd;
  logic             [31:0] stat_rd;
  logic             [1:0]  to_evt;
  logic             [1:0]  line_low;

  smc_tick_if tk ();

  assign wr_ctrl = reg_wr && reg_addr == CTRL_OFS;
  assign wr_stat = reg_wr && reg_addr == STAT_OFS;

  // ******
  // Control register
  // ******

  // Boot strap caught on the first edge after reset release
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      boot_done_ff <= 1'b0;
      prescale_ff  <= PRESCALE_RST;
    end
    else if (!boot_done_ff)
    begin
      boot_done_ff <= 1'b1;
      prescale_ff  <= boot_fast_mode ? PRESCALE_FAST : PRESCALE_SLOW;
    end
    else if (wr_ctrl)
    begin
      prescale_ff  <= reg_wdata[PRESCALE_MSB:PRESCALE_LSB];
    end
  end

  // Mode and option bits, upper bits not stored
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      ign_arb_ff  <= 1'b0;
      ign_csum_ff <= 1'b0;
      slv_mode_ff <= GM_NORMAL;
      mst_mode_ff <= GM_NORMAL;
      to_dis_ff   <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      ign_arb_ff  <= reg_wdata[IGN_ARB_BIT];
      ign_csum_ff <= reg_wdata[IGN_CSUM_BIT];
      slv_mode_ff <= smc_glitch_mode_t'(reg_wdata[SLV_GLITCH_LSB +: 2]);
      mst_mode_ff <= smc_glitch_mode_t'(reg_wdata[MST_GLITCH_LSB +: 2]);
      to_dis_ff   <= reg_wdata[TO_DIS_BIT];
    end
  end

  assign boot_initialised = boot_done_ff;

  // ******
  // Line filters
  // ******
  smc_glitch_filter u_mclk_filt
  (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .mode  (mst_mode_ff),
    .raw   (master_port_clock_line_i),
    .filt  (mst_clk_in)
  );

  smc_glitch_filter u_mdat_filt
  (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .mode  (mst_mode_ff),
    .raw   (master_port_data_line_i),
    .filt  (mst_data_in)
  );

  smc_glitch_filter u_sclk_filt
  (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .mode  (slv_mode_ff),
    .raw   (slave_port_clock_line_i),
    .filt  (slv_clk_in)
  );

  smc_glitch_filter u_sdat_filt
  (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .mode  (slv_mode_ff),
    .raw   (slave_port_data_line_i),
    .filt  (slv_data_in)
  );

  // ******
  // Master clock generation
  // ******
  assign tk.prescale   = prescale_ff;
  assign tk.run        = (arb_ff == ARB_ACTIVE);
  assign mst_half_tick = tk.half_tick;

  smc_prescaler u_presc
  (
    .clk   (clk),
    .rst_n (rst_sync_ff),
    .tk    (tk)
  );

  // Low and high phases each last one half period
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      scl_high_ff <= 1'b1;
    end
    else if (!tk.run || tk.stopped)
    begin
      scl_high_ff <= 1'b1;
    end
    else if (tk.half_tick)
    begin
      scl_high_ff <= ~scl_high_ff;
    end
  end

  // Data drive taken only while holding the bus
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      sda_drive_ff <= 1'b0;
    end
    else
    begin
      sda_drive_ff <= (arb_ff == ARB_ACTIVE) && !mst_data_out;
    end
  end

  // Open-drain pins only ever pull low
  assign master_port_clock_line_o  = 1'b0;
  assign master_port_clock_line_oe = ~scl_high_ff;
  assign master_port_data_line_o   = 1'b0;
  assign master_port_data_line_oe  = sda_drive_ff;
  assign slave_port_clock_line_o   = 1'b0;
  assign slave_port_clock_line_oe  = 1'b0;
  assign slave_port_data_line_o    = 1'b0;

  // Slave data drive registered
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      slave_port_data_line_oe <= 1'b0;
    end
    else
    begin
      slave_port_data_line_oe <= slv_data_low;
    end
  end

  // ******
  // Arbitration
  // ******

  // Released data seen low at end of a high phase is a loss
  assign loss_evt  = (arb_ff == ARB_ACTIVE) && tk.half_tick && scl_high_ff &&
                     !sda_drive_ff && !mst_data_in && !ign_arb_ff;
  assign abort_evt = loss_evt && (loss_cnt_ff == 5'(ARB_LOSS_LIMIT - 1));
  assign bus_idle  = mst_clk_in && mst_data_in;

  // Next arbitration state
  always_comb
  begin
    nxt_arb = arb_ff;
    case (arb_ff)
      ARB_IDLE:
        if (mst_run)
          nxt_arb = ARB_ACTIVE;
      ARB_ACTIVE:
        if (abort_evt)
          nxt_arb = ARB_ABORT;
        else if (loss_evt)
          nxt_arb = ARB_BACKOFF;
        else if (mst_txn_done || !mst_run)
          nxt_arb = ARB_IDLE;
      ARB_BACKOFF:
        if (!mst_run)
          nxt_arb = ARB_IDLE;
        else if (bus_idle)
          nxt_arb = ARB_ACTIVE;
      ARB_ABORT:
        if (!mst_run)
          nxt_arb = ARB_IDLE;
      default:
        nxt_arb = ARB_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      arb_ff <= ARB_IDLE;
    end
    else
    begin
      arb_ff <= nxt_arb;
    end
  end

  // Consecutive loss count, cleared on completion or abort
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      loss_cnt_ff <= 5'h00;
    end
    else if (abort_evt || (arb_ff == ARB_ACTIVE && mst_txn_done))
    begin
      loss_cnt_ff <= 5'h00;
    end
    else if (loss_evt)
    begin
      loss_cnt_ff <= loss_cnt_ff + 5'h01;
    end
  end

  // Abort pulse
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      arb_abort <= 1'b0;
    end
    else
    begin
      arb_abort <= abort_evt;
    end
  end

  // ******
  // Time-outs and checksum
  // ******
  assign line_low = {~slv_clk_in, ~mst_clk_in};

  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_to
      logic [19:0] cnt_ff;
      // Clock held low too long, one report per low stretch
      always_ff @(posedge clk or negedge rst_sync_ff)
      begin
        if (!rst_sync_ff)
        begin
          cnt_ff   <= 20'h00000;
          to_evt[g] <= 1'b0;
        end
        else if (!line_low[g] || to_dis_ff)
        begin
          cnt_ff   <= 20'h00000;
          to_evt[g] <= 1'b0;
        end
        else if (cnt_ff == 20'(TIMEOUT_CYCLES - 1))
        begin
          cnt_ff   <= cnt_ff + 20'h00001;
          to_evt[g] <= 1'b1;
        end
        else
        begin
          cnt_ff   <= (cnt_ff == 20'hFFFFF) ? cnt_ff : cnt_ff + 20'h00001;
          to_evt[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign master_timeout = to_evt[0];
  assign slave_timeout  = to_evt[1];

  // Checksum result pulse
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      csum_error <= 1'b0;
    end
    else
    begin
      csum_error <= csum_check && !csum_ok && !ign_csum_ff;
    end
  end

  // ******
  // Status flags, set wins over write-one-to-clear
  // ******
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      lost_arbitration_flag_ff <= 1'b0;
      mst_to_flag_ff           <= 1'b0;
      slv_to_flag_ff           <= 1'b0;
      csum_flag_ff             <= 1'b0;
    end
    else
    begin
      lost_arbitration_flag_ff <= arb_abort ||
        (lost_arbitration_flag_ff && !(wr_stat && reg_wdata[ST_LOST_ARB_BIT]));
      mst_to_flag_ff <= to_evt[0] ||
        (mst_to_flag_ff && !(wr_stat && reg_wdata[ST_MST_TO_BIT]));
      slv_to_flag_ff <= to_evt[1] ||
        (slv_to_flag_ff && !(wr_stat && reg_wdata[ST_SLV_TO_BIT]));
      csum_flag_ff   <= csum_error ||
        (csum_flag_ff && !(wr_stat && reg_wdata[ST_CSUM_BIT]));
    end
  end

  // ******
  // Read data
  // ******
  always_comb
  begin
    ctrl_rd                            = 32'h00000000;
    ctrl_rd[PRESCALE_MSB:PRESCALE_LSB] = prescale_ff;
    ctrl_rd[IGN_ARB_BIT]               = ign_arb_ff;
    ctrl_rd[IGN_CSUM_BIT]              = ign_csum_ff;
    ctrl_rd[SLV_GLITCH_LSB +: 2]       = slv_mode_ff;
    ctrl_rd[MST_GLITCH_LSB +: 2]       = mst_mode_ff;
    ctrl_rd[TO_DIS_BIT]                = to_dis_ff;
    stat_rd                            = 32'h00000000;
    stat_rd[ST_LOST_ARB_BIT]           = lost_arbitration_flag_ff;
    stat_rd[ST_MST_TO_BIT]             = mst_to_flag_ff;
    stat_rd[ST_SLV_TO_BIT]             = slv_to_flag_ff;
    stat_rd[ST_CSUM_BIT]               = csum_flag_ff;
    stat_rd[ST_LOSS_CNT_LSB +: 5]      = loss_cnt_ff;
    stat_rd[ST_STATE_LSB +: 2]         = arb_ff;
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      reg_rdata <= 32'h00000000;
    end
    else if (reg_rd && reg_addr == CTRL_OFS)
    begin
      reg_rdata <= ctrl_rd;
    end
    else if (reg_rd && reg_addr == STAT_OFS)
    begin
      reg_rdata <= stat_rd;
    end
    else
    begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // smc_ctrl

// >>> logic/smc_glitch_filter.sv
`timescale 1ns/1ps
module smc_glitch_filter
  import smc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire smc_glitch_mode_t mode,
  input  wire logic             raw,
  output logic                  filt
);

  logic [4:0] cnt_ff;
  logic [4:0] limit;

  // Delay in cycles per mode, reserved acts as normal
  always_comb
  begin
    case (mode)
      GM_FAST: limit = 5'(GLITCH_FAST_CYC);
      GM_OFF:  limit = 5'h01;
      default: limit = 5'(GLITCH_NORMAL_CYC);
    endcase
  end

  // Level must stand for the whole delay before it passes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 5'h00;
      filt   <= 1'b1;
    end
    else if (mode == GM_OFF || raw == filt)
    begin
      cnt_ff <= 5'h00;
      filt   <= raw;
    end
    else if (cnt_ff >= limit - 5'h01)
    begin
      cnt_ff <= 5'h00;
      filt   <= raw;
    end
    else
    begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

endmodule // smc_glitch_filter

// >>> logic/smc_pkg.sv
package smc_pkg;

  // ******
  // Clocking and timing
  // ******
  localparam int unsigned CLK_PERIOD_NS       = 50;
  localparam int unsigned PRESCALE_UNIT_NS    = 32;
  localparam int unsigned GLITCH_NORMAL_NS    = 1000;
  localparam int unsigned GLITCH_FAST_NS      = 100;
  localparam int unsigned GLITCH_NORMAL_CYC   =
    (GLITCH_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_FAST_CYC     =
    (GLITCH_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_US          = 25000;
  localparam int unsigned TIMEOUT_CYC         = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ARB_LOSS_LIMIT      = 16;

  // ******
  // Register map
  // ******
  localparam logic [11:0] CTRL_OFS            = 12'h348;
  localparam logic [11:0] STAT_OFS            = 12'h3F0;
  localparam int unsigned PRESCALE_LSB        = 0;
  localparam int unsigned PRESCALE_MSB        = 15;
  localparam int unsigned IGN_ARB_BIT         = 16;
  localparam int unsigned IGN_CSUM_BIT        = 17;
  localparam int unsigned SLV_GLITCH_LSB      = 18;
  localparam int unsigned MST_GLITCH_LSB      = 20;
  localparam int unsigned TO_DIS_BIT          = 22;
  localparam int unsigned ST_LOST_ARB_BIT     = 0;
  localparam int unsigned ST_MST_TO_BIT       = 1;
  localparam int unsigned ST_SLV_TO_BIT       = 2;
  localparam int unsigned ST_CSUM_BIT         = 3;
  localparam int unsigned ST_LOSS_CNT_LSB     = 4;
  localparam int unsigned ST_STATE_LSB        = 9;
  localparam logic [15:0] PRESCALE_SLOW       = 16'h0139;
  localparam logic [15:0] PRESCALE_FAST       = 16'h0053;
  localparam logic [15:0] PRESCALE_RST        = 16'h0139;

  // ******
  // Types
  // ******
  typedef enum logic [1:0] {
    GM_NORMAL = 2'h0,
    GM_FAST   = 2'h1,
    GM_OFF    = 2'h2,
    GM_RSVD   = 2'h3
  } smc_glitch_mode_t;

  typedef enum logic [1:0] {
    ARB_IDLE    = 2'h0,
    ARB_ACTIVE  = 2'h1,
    ARB_BACKOFF = 2'h3,
    ARB_ABORT   = 2'h2
  } smc_arb_state_t;

endpackage

// >>> logic/smc_prescaler.sv
`timescale 1ns/1ps
module smc_prescaler
  import smc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  smc_tick_if.gen   tk
);

  logic [20:0] acc_ff;
  logic [20:0] thr;
  logic [20:0] acc_sum;

  // Half period is 16 ns per count, half the 32 ns unit
  assign thr        = {1'b0, tk.prescale, 4'h0};
  assign acc_sum    = acc_ff + 21'(CLK_PERIOD_NS);
  assign tk.stopped = (tk.prescale <= 16'h0001);

  // Phase accumulator in ns, one tick per half period on average
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_ff       <= 21'h000000;
      tk.half_tick <= 1'b0;
    end
    else if (tk.stopped || !tk.run)
    begin
      acc_ff       <= 21'h000000;
      tk.half_tick <= 1'b0;
    end
    else if (acc_sum >= thr)
    begin
      acc_ff       <= acc_sum - thr;
      tk.half_tick <= 1'b1;
    end
    else
    begin
      acc_ff       <= acc_sum;
      tk.half_tick <= 1'b0;
    end
  end

endmodule // smc_prescaler

// >>> logic/smc_tick_if.sv
`timescale 1ns/1ps
interface smc_tick_if;
  import smc_pkg::*;
  logic [15:0] prescale;
  logic        run;
  logic        half_tick;
  logic        stopped;
  modport gen  (input prescale, input run, output half_tick, output stopped);
  modport user (output prescale, output run, input half_tick, input stopped);
endinterface

// >>> tb/smc_bus_model.sv
`timescale 1ns/1ps
// ******
// Far-side open-drain bus segments
// ******
module smc_bus_model
(
  input  wire logic m_clk_oe,
  input  wire logic m_dat_oe,
  input  wire logic s_clk_oe,
  input  wire logic s_dat_oe,
  input  wire logic m_clk_pull,
  input  wire logic m_dat_pull,
  input  wire logic s_clk_pull,
  input  wire logic s_dat_pull,
  output logic      m_clk,
  output logic      m_dat,
  output logic      s_clk,
  output logic      s_dat
);
  // Wired-AND, released lines rise through pull-ups
  assign m_clk = !(m_clk_oe || m_clk_pull);
  assign m_dat = !(m_dat_oe || m_dat_pull);
  assign s_clk = !(s_clk_oe || s_clk_pull);
  assign s_dat = !(s_dat_oe || s_dat_pull);
endmodule // smc_bus_model

// >>> tb/smc_ctrl_monitor.sv
`timescale 1ns/1ps
// ******
// Port-level checker for the control block
// ******
module smc_ctrl_monitor
  import smc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        boot_fast_mode,
  input wire logic        mst_run,
  input wire logic        mst_half_tick,
  input wire logic        arb_abort,
  input wire logic        slave_port_clock_line_i,
  input wire logic        slv_clk_in,
  input wire logic        master_timeout,
  input wire logic        slave_timeout,
  input wire logic        csum_check,
  input wire logic        csum_ok,
  input wire logic        csum_error
);
  logic [22:0] sh_ff;
  logic        wr_ff;
  logic        sin_ff;
  logic [9:0]  wage_ff;
  logic [9:0]  gap_ff;
  logic [4:0]  scnt_ff;
  logic [15:0] pre;
  logic [31:0] lo;
  logic [4:0]  need;
  logic        cwr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Expected prescale, spacing, filter
  assign cwr  = reg_wr && (reg_addr == CTRL_OFS);
  assign pre  = wr_ff ? sh_ff[15:0] : (boot_fast_mode ? PRESCALE_FAST : PRESCALE_SLOW);
  assign lo   = (32'(pre) * 32'h10) / CLK_PERIOD_NS;
  assign need = (sh_ff[19:18] == 2'h2) ? 5'h1 : (sh_ff[19:18] == 2'h1) ? 5'h2 : 5'h14;

  // Shadow, write age, tick gap, stability
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      sh_ff   <= 23'h0;
      wr_ff   <= 1'b0;
      sin_ff  <= 1'b1;
      wage_ff <= 10'h0;
      gap_ff  <= 10'h0;
      scnt_ff <= 5'h0;
    end
    else
    begin
      if (cwr)
      begin
        sh_ff <= reg_wdata[22:0];
        wr_ff <= 1'b1;
      end
      wage_ff <= cwr ? 10'h0 : wage_ff + {9'h0, wage_ff != 10'h3FF};
      gap_ff  <= mst_half_tick ? 10'h1 : gap_ff + {9'h0, gap_ff != 10'h3FF};
      sin_ff  <= slave_port_clock_line_i;
      scnt_ff <= (slave_port_clock_line_i != sin_ff) ? 5'h0 : scnt_ff + {4'h0, scnt_ff != 5'h1F};
    end

  property p_rd_ctrl;
    reg_rd && reg_addr == CTRL_OFS |=> reg_rdata == {9'h0, sh_ff[22:16], pre};
  endproperty
  property p_stop;
    pre <= 16'h1 && wage_ff >= 10'h4 |-> !mst_half_tick;
  endproperty
  property p_period;
    mst_half_tick && mst_run && pre > 16'h3 && {1'b0, gap_ff} + 11'h4 < {1'b0, wage_ff}
      |-> gap_ff >= lo && gap_ff <= lo + 1;
  endproperty
  property p_csum_err;
    csum_check && !csum_ok && !sh_ff[17] |=> csum_error;
  endproperty
  property p_csum_pass;
    csum_check && (csum_ok || sh_ff[17]) |=> !csum_error;
  endproperty
  property p_to_dis;
    sh_ff[22] && $past(sh_ff[22]) |-> !master_timeout && !slave_timeout;
  endproperty
  property p_ign_arb;
    sh_ff[16] && $past(sh_ff[16]) |-> !arb_abort;
  endproperty
  property p_glitch;
    $changed(slv_clk_in) && wage_ff > 10'h18 |-> scnt_ff >= need - 5'h1;
  endproperty

  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read mismatch");
  a_stop: assert property (p_stop) else $error("tick while stopped");
  a_period: assert property (p_period) else $error("tick spacing wrong");
  a_csum_err: assert property (p_csum_err) else $error("checksum error missing");
  a_csum_pass: assert property (p_csum_pass) else $error("checksum error raised");
  a_to_dis: assert property (p_to_dis) else $error("timeout while disabled");
  a_ign_arb: assert property (p_ign_arb) else $error("abort while ignoring");
  a_glitch: assert property (p_glitch) else $error("filter passed too early");

  c_tick: cover property (mst_half_tick);
  c_abort: cover property (arb_abort);
  c_tmo: cover property (slave_timeout);
  c_csum: cover property (csum_error);
endmodule // smc_ctrl_monitor

// >>> tb/smc_ctrl_tb.sv
`timescale 1ns/1ps
// ******
// Self-checking bench for the control block
// ******
module smc_ctrl_tb;
  import smc_pkg::*;
  localparam int unsigned TO_CYC = 40;
  logic        clk, rst_n, reg_wr, reg_rd, boot_fast_mode, boot_init;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        mst_run, mst_data_out, mst_txn_done, slv_data_low, csum_check, csum_ok;
  logic        mc_oe, md_oe, sc_oe, sd_oe, mc, md, sc, sd, pull_mc, pull_md, pull_sc, pull_sd;
  logic        mst_clk_in, mst_data_in, tick, arb_abort, slv_clk_in, slv_data_in;
  logic        mst_to, slv_to, csum_error;
  int          n_mismatch, num_checks;

  // Design and far-side bus
  smc_ctrl #(.TIMEOUT_CYCLES(TO_CYC)) dut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .boot_fast_mode,
    .boot_initialised(boot_init), .master_port_clock_line_i(mc),
    .master_port_clock_line_o(), .master_port_clock_line_oe(mc_oe),
    .master_port_data_line_i(md), .master_port_data_line_o(), .master_port_data_line_oe(md_oe),
    .slave_port_clock_line_i(sc), .slave_port_clock_line_o(), .slave_port_clock_line_oe(sc_oe),
    .slave_port_data_line_i(sd), .slave_port_data_line_o(), .slave_port_data_line_oe(sd_oe),
    .mst_run, .mst_data_out, .mst_txn_done, .mst_clk_in, .mst_data_in,
    .mst_half_tick(tick), .arb_abort, .slv_data_low, .slv_clk_in, .slv_data_in,
    .master_timeout(mst_to), .slave_timeout(slv_to), .csum_check, .csum_ok, .csum_error);
  smc_bus_model u_bus (.m_clk_oe(mc_oe), .m_dat_oe(md_oe), .s_clk_oe(sc_oe), .s_dat_oe(sd_oe),
    .m_clk_pull(pull_mc), .m_dat_pull(pull_md), .s_clk_pull(pull_sc), .s_dat_pull(pull_sd),
    .m_clk(mc), .m_dat(md), .s_clk(sc), .s_dat(sd));

  // Clock and run-length guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask
  task automatic do_reset(input logic fast);
    rst_n <= 1'b0;
    boot_fast_mode <= fast;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    do_reset(1'b1);
    rd(CTRL_OFS, d);
    chk("fast boot", d, 32'h00000053);
    do_reset(1'b0);
    rd(CTRL_OFS, d);
    chk("slow boot", d, 32'h00000139);
    chk("boot done", {31'h0, boot_init}, 32'h1);
    wr(CTRL_OFS, 32'hFFFFFFFF);
    rd(CTRL_OFS, d);
    chk("ctrl bits", d, 32'h007FFFFF);
    wr(12'h100, 32'hFFFFFFFF);
    rd(12'h100, d);
    chk("unmapped", d, 32'h0);
  endtask
  task automatic t_presc();
    int n;
    int k;
    wr(CTRL_OFS, 32'h00280053);
    mst_run <= 1'b1;
    n = 0;
    k = -1;
    while (k < 10)
    begin
      @(negedge clk);
      if (k >= 0) n++;
      if (tick === 1'b1) k++;
    end
    k = (32'h10 * 32'h53 * 32'hA) / CLK_PERIOD_NS;
    chk("ten halves", {31'h0, n == k || n == k + 1}, 32'h1);
    @(posedge clk);
    for (int p = 0; p < 2; p++)
    begin
      wr(CTRL_OFS, 32'h00280000 | p);
      repeat (8) @(negedge clk);
      k = 0;
      repeat (200)
      begin
        @(negedge clk);
        k += (tick !== 1'b0) + (mc_oe !== 1'b0);
      end
      chk("stopped", k, 0);
      @(posedge clk);
    end
    mst_run <= 1'b0;
  endtask
  task automatic t_arb(input logic ign);
    bit seen;
    logic [31:0] d;
    seen = 0;
    wr(CTRL_OFS, 32'h00200002 | (32'(ign) << 16));
    mst_run <= 1'b1;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clk);
      pull_md <= i[2];
      seen |= (arb_abort === 1'b1);
    end
    mst_run <= 1'b0;
    pull_md <= 1'b0;
    chk("abort", seen, !ign);
    rd(STAT_OFS, d);
    chk("lost flag", d[ST_LOST_ARB_BIT], !ign);
    wr(STAT_OFS, 32'h1);
    mst_txn_done <= 1'b1;
    @(posedge clk);
    mst_txn_done <= 1'b0;
  endtask
  task automatic lat(input logic [1:0] m, output int ds, output int dm);
    wr(CTRL_OFS, 32'h00400000 | (32'(m) << 20) | (32'(m) << 18));
    repeat (30) @(posedge clk);
    pull_sc <= 1'b1;
    pull_md <= 1'b1;
    ds = 0;
    dm = 0;
    for (int i = 1; i < 40; i++)
    begin
      @(negedge clk);
      if (ds == 0 && slv_clk_in === 1'b0) ds = i;
      if (dm == 0 && mst_data_in === 1'b0) dm = i;
    end
    @(posedge clk);
    pull_sc <= 1'b0;
    pull_md <= 1'b0;
    repeat (30) @(posedge clk);
  endtask
  task automatic t_filt();
    int ds[4];
    int dm[4];
    for (int m = 0; m < 4; m++)
      lat(m[1:0], ds[m], dm[m]);
    chk("slave normal", ds[0] - ds[2], GLITCH_NORMAL_CYC - 1);
    chk("slave fast", ds[1] - ds[2], GLITCH_FAST_CYC - 1);
    chk("slave rsvd", ds[3], ds[0]);
    chk("master normal", dm[0] - dm[2], GLITCH_NORMAL_CYC - 1);
    chk("master fast", dm[1] - dm[2], GLITCH_FAST_CYC - 1);
  endtask
  task automatic t_tmo(input logic dis);
    int m;
    int s;
    wr(CTRL_OFS, 32'h00280000 | (32'(dis) << 22));
    pull_mc <= 1'b1;
    pull_sc <= 1'b1;
    m = 0;
    s = 0;
    repeat (TO_CYC * 2)
    begin
      @(negedge clk);
      m += (mst_to === 1'b1);
      s += (slv_to === 1'b1);
    end
    @(posedge clk);
    pull_mc <= 1'b0;
    pull_sc <= 1'b0;
    chk("master timeout", m, !dis);
    chk("slave timeout", s, !dis);
    repeat (10) @(posedge clk);
  endtask
  task automatic t_csum();
    logic [2:0] v[3] = '{3'b001, 3'b100, 3'b010};
    for (int i = 0; i < 3; i++)
    begin
      wr(CTRL_OFS, 32'(v[i][2]) << 17);
      csum_ok <= v[i][1];
      csum_check <= 1'b1;
      @(posedge clk);
      csum_check <= 1'b0;
      @(negedge clk);
      chk("csum error", csum_error, v[i][0]);
      @(posedge clk);
    end
  endtask

  // Main sequence
  initial
  begin
    {reg_wr, reg_rd, mst_run, mst_txn_done, slv_data_low, csum_check, csum_ok} = '0;
    {pull_mc, pull_md, pull_sc, pull_sd} = '0;
    {mst_data_out, boot_fast_mode, rst_n} = 3'h6;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    n_mismatch = 0;
    num_checks = 0;
    @(posedge clk);
    t_regs();
    t_presc();
    t_arb(1'b0);
    t_arb(1'b1);
    t_filt();
    t_tmo(1'b0);
    t_tmo(1'b1);
    t_csum();
    give_verdict();
  end
endmodule // smc_ctrl_tb

bind smc_ctrl smc_ctrl_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (.*);
